/* File: design/hsp_pkg.sv */
// Package of constants and types for the host serial register port
package hsp_pkg;
	// ----------------------------------------
	// Register bank geometry
	// ----------------------------------------
	localparam int HSP_REG_COUNT = 32;
	localparam int HSP_ADDR_W = 5;
	localparam int HSP_DATA_W = 8;
	// ----------------------------------------
	// Command frame layout, bit counts from select assertion
	// ----------------------------------------
	localparam logic [4:0] HSP_BIT_DIR = 5'h01;
	localparam logic [4:0] HSP_BIT_ADDR_FIRST = 5'h02;
	localparam logic [4:0] HSP_BIT_ADDR_LAST = 5'h06;
	localparam logic [4:0] HSP_BIT_CMD_LAST = 5'h08;
	localparam logic [4:0] HSP_BIT_DATA_LAST = 5'h10;
	localparam logic HSP_DIR_READ = 1'h1;
	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [7:0] HSP_REG_RESET = 8'h00;
	localparam int HSP_SYNC_STAGES = 2;
	typedef enum logic [2:0] {
		HSP_IDLE = 3'b001,
		HSP_CMD = 3'b010,
		HSP_DATA = 3'b100
	} hsp_state_t;
endpackage : hsp_pkg

/* File: design/hsp_sync.sv */
// Two-flop synchroniser bank for the serial pins
`timescale 1ns/10ps
module hsp_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	// Data
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	import hsp_pkg::*;
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic meta_ff;
			logic stab_ff;
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					meta_ff <= 1'h0;
					stab_ff <= 1'h0;
				end else if (en_i) begin
					meta_ff <= async_i[g];
					stab_ff <= meta_ff;
				end
			end
			assign sync_o[g] = stab_ff;
		end
	endgenerate
endmodule : hsp_sync

/* File: design/hsp_port.sv */
// Host serial register port with its 32 byte register bank
// Summary of operation
// - Port works only while mode select low
// - Thirty-two readable writable eight-bit registers
// - Active-low select frames each transaction
// - Eight command bits sampled on rising edges
// - First bit: one reads, zero writes
// - Five address bits, LSB first
// - Two idle clocks before data bits
// - Output driven from ninth rising edge
// - Read data shifted out LSB first
// - Write bits captured on rising edges, stored
`timescale 1ns/10ps
module hsp_port #(
	parameter int REG_COUNT = hsp_pkg::HSP_REG_COUNT,
	parameter int ADDR_W = hsp_pkg::HSP_ADDR_W,
	parameter int DATA_W = hsp_pkg::HSP_DATA_W
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	// Mode select, low selects host mode
	input wire logic control_mode_select_i,
	// Serial pins
	input wire logic select_n_i,
	input wire logic serial_clk_i,
	input wire logic serial_data_in_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_o,
	// Register bank view for the rest of the device
	input wire logic [ADDR_W-1:0] reg_rd_addr_i,
	output logic [DATA_W-1:0] reg_rd_data_o,
	output logic [ADDR_W-1:0] register_index_o,
	output logic [DATA_W-1:0] payload_byte_o,
	output logic reg_wr_strobe_o
);
	import hsp_pkg::*;
	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	logic [3:0] pins_sync;
	logic sel_n_s;
	logic sclk_s;
	logic sdi_s;
	logic mode_s;
	// Select and mode pass inverted, so the cleared flops read as deselected and
	// pin mode; otherwise reset release would look like a frame opening
	hsp_sync #(.WIDTH(4)) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.en_i(clk_en_i),
		.async_i({~control_mode_select_i, serial_data_in_i, serial_clk_i, ~select_n_i}),
		.sync_o(pins_sync)
	);
	assign sel_n_s = !pins_sync[0];
	assign sclk_s = pins_sync[1];
	assign sdi_s = pins_sync[2];
	assign mode_s = !pins_sync[3];
	// ----------------------------------------
	// Edge detection and framing
	// ----------------------------------------
	logic sclk_d_ff;
	hsp_state_t state_ff;
	hsp_state_t nxt_state;
	logic [4:0] bit_cnt_ff;
	logic dir_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [DATA_W-1:0] shift_ff;
	logic [DATA_W-1:0] rd_byte_ff;
	logic sdo_ff;
	logic oe_ff;
	logic [ADDR_W-1:0] wr_addr_ff;
	logic [DATA_W-1:0] wr_data_ff;
	logic wr_stb_ff;
	logic [DATA_W-1:0] bank_ff [REG_COUNT];
	wire active = !mode_s && !sel_n_s;
	wire rise = sclk_s && !sclk_d_ff;
	wire fall = !sclk_s && sclk_d_ff;
	wire [4:0] nxt_cnt = bit_cnt_ff + 5'h01;
	wire in_addr = (nxt_cnt >= HSP_BIT_ADDR_FIRST) && (nxt_cnt <= HSP_BIT_ADDR_LAST);
	wire cmd_done = rise && (nxt_cnt == HSP_BIT_CMD_LAST);
	wire data_done = rise && (nxt_cnt == HSP_BIT_DATA_LAST);
	wire is_read = (dir_ff == HSP_DIR_READ);
	wire [ADDR_W-1:0] addr_shifted = {sdi_s, addr_ff[ADDR_W-1:1]};
	wire [DATA_W-1:0] data_shifted = {sdi_s, shift_ff[DATA_W-1:1]};
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			HSP_IDLE: begin
				if (active) begin
					nxt_state = HSP_CMD;
				end
			end
			HSP_CMD: begin
				if (!active) begin
					nxt_state = HSP_IDLE;
				end else if (cmd_done) begin
					nxt_state = HSP_DATA;
				end
			end
			HSP_DATA: begin
				// Held until deselect so rises past the sixteenth start nothing
				if (!active) begin
					nxt_state = HSP_IDLE;
				end
			end
			default: nxt_state = HSP_IDLE;
		endcase
	end
	// ----------------------------------------
	// Command and data shifting
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_d_ff <= 1'h0;
			state_ff <= HSP_IDLE;
			bit_cnt_ff <= 5'h00;
			dir_ff <= 1'h0;
			addr_ff <= '0;
			shift_ff <= '0;
		end else if (clk_en_i) begin
			sclk_d_ff <= sclk_s;
			state_ff <= nxt_state;
			if (!active || state_ff == HSP_IDLE) begin
				bit_cnt_ff <= 5'h00;
			end else if (rise && bit_cnt_ff != HSP_BIT_DATA_LAST) begin
				// Counting stops at the last data bit; stray rises are ignored
				bit_cnt_ff <= nxt_cnt;
				if (nxt_cnt == HSP_BIT_DIR) begin
					dir_ff <= sdi_s;
				end
				if (in_addr) begin
					addr_ff <= addr_shifted;
				end
				// Bits seven and eight are not stored; bit seven is left to the host
				if (state_ff == HSP_DATA) begin
					shift_ff <= data_shifted;
				end
			end
		end
	end
	// ----------------------------------------
	// Read data output
	// ----------------------------------------
	// Byte is loaded during the idle bits, launched at the ninth rising edge
	// One snapshot per frame, so a device-side change mid-read cannot tear the byte
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_byte_ff <= '0;
			sdo_ff <= 1'h0;
			oe_ff <= 1'h0;
		end else if (clk_en_i) begin
			if (cmd_done) begin
				rd_byte_ff <= bank_ff[addr_ff];
			end
			if (!active || state_ff != HSP_DATA || !is_read) begin
				oe_ff <= 1'h0;
			end else if (rise && bit_cnt_ff == HSP_BIT_CMD_LAST) begin
				oe_ff <= 1'h1;
				sdo_ff <= rd_byte_ff[0];
				rd_byte_ff <= {1'h0, rd_byte_ff[DATA_W-1:1]};
			end else if (rise && oe_ff && bit_cnt_ff != HSP_BIT_DATA_LAST) begin
				sdo_ff <= rd_byte_ff[0];
				rd_byte_ff <= {1'h0, rd_byte_ff[DATA_W-1:1]};
			end else if (fall && bit_cnt_ff == HSP_BIT_DATA_LAST) begin
				// Last bit stands until the host has taken it on the falling edge
				oe_ff <= 1'h0;
			end
		end
	end
	// ----------------------------------------
	// Register bank and write commit
	// ----------------------------------------
	// Only a whole frame reaches the sixteenth rise, so a cut frame never writes
	wire commit = clk_en_i && active && state_ff == HSP_DATA && data_done && !is_read;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_addr_ff <= '0;
			wr_data_ff <= '0;
			wr_stb_ff <= 1'h0;
		end else if (clk_en_i) begin
			wr_stb_ff <= commit;
			if (commit) begin
				wr_addr_ff <= addr_ff;
				wr_data_ff <= data_shifted;
			end
		end
	end
	genvar r;
	generate
		for (r = 0; r < REG_COUNT; r++) begin : g_reg
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					bank_ff[r] <= HSP_REG_RESET;
				end else if (commit && addr_ff == ADDR_W'(r)) begin
					bank_ff[r] <= data_shifted;
				end
			end
		end
	endgenerate
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Tristate is resolved outside; low enable means high impedance
	assign serial_data_out_o = sdo_ff;
	assign serial_data_out_oe_o = oe_ff;
	// Device-side read is combinational and independent of the serial snapshot
	assign reg_rd_data_o = bank_ff[reg_rd_addr_i];
	assign register_index_o = wr_addr_ff;
	assign payload_byte_o = wr_data_ff;
	assign reg_wr_strobe_o = wr_stb_ff;
endmodule : hsp_port

/* File: tb/hsp_port_assertions.sv */
// Concurrent checks on the host serial register port pins
`timescale 1ns/10ps
module hsp_port_assertions #(
	parameter int ADDR_W = 5,
	parameter int DATA_W = 8
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	// Serial pins
	input wire logic control_mode_select_i,
	input wire logic select_n_i,
	input wire logic serial_clk_i,
	input wire logic serial_data_in_i,
	input wire logic serial_data_out_o,
	input wire logic serial_data_out_oe_o,
	// Bank view
	input wire logic [ADDR_W-1:0] reg_rd_addr_i,
	input wire logic [DATA_W-1:0] reg_rd_data_o,
	input wire logic [ADDR_W-1:0] register_index_o,
	input wire logic [DATA_W-1:0] payload_byte_o,
	input wire logic reg_wr_strobe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_mode; control_mode_select_i [*5] |-> !serial_data_out_oe_o; endproperty
	a_mode: assert property (p_mode) else $error("pin driven in pin mode");
	property p_oe_rise; $rose(serial_data_out_oe_o) |-> $past(serial_clk_i, 2); endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("drive began off a clock rise");
	property p_shift; serial_data_out_oe_o && $past(serial_data_out_oe_o)
		&& $changed(serial_data_out_o) |-> $past(serial_clk_i, 2); endproperty
	a_shift: assert property (p_shift) else $error("data bit moved off a clock rise");
	property p_pulse; reg_wr_strobe_o |=> !reg_wr_strobe_o; endproperty
	a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
	property p_bank; reg_wr_strobe_o && reg_rd_addr_i == register_index_o
		|-> reg_rd_data_o == payload_byte_o; endproperty
	a_bank: assert property (p_bank) else $error("bank misses committed byte");
	property p_sel; reg_wr_strobe_o |-> !$past(select_n_i, 4)
		&& !$past(control_mode_select_i, 4); endproperty
	a_sel: assert property (p_sel) else $error("write without live frame");
	property p_idle; select_n_i [*5] |-> !serial_data_out_oe_o; endproperty
	a_idle: assert property (p_idle) else $error("pin driven while deselected");
	property p_wr_quiet; reg_wr_strobe_o |-> !serial_data_out_oe_o; endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("pin driven in a write");
	c_read: cover property ($rose(serial_data_out_oe_o));
	c_write: cover property (reg_wr_strobe_o);
	c_mode: cover property (control_mode_select_i && !select_n_i);
endmodule : hsp_port_assertions
bind hsp_port hsp_port_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
	.control_mode_select_i(control_mode_select_i), .select_n_i(select_n_i),
	.serial_clk_i(serial_clk_i), .serial_data_in_i(serial_data_in_i),
	.serial_data_out_o(serial_data_out_o), .serial_data_out_oe_o(serial_data_out_oe_o),
	.reg_rd_addr_i(reg_rd_addr_i), .reg_rd_data_o(reg_rd_data_o),
	.register_index_o(register_index_o), .payload_byte_o(payload_byte_o),
	.reg_wr_strobe_o(reg_wr_strobe_o));

/* File: tb/hsp_host_model.sv */
// Serial host model that frames commands into the register port
`timescale 1ns/10ps
module hsp_host_model (
	// Clock
	input wire logic clk_i,
	// Serial pins
	output logic select_n_o,
	output logic serial_clk_o,
	output logic serial_data_o,
	input wire logic serial_data_out_i,
	input wire logic serial_data_out_oe_i
);
	initial begin
		select_n_o = 1'b1;
		serial_clk_o = 1'b0;
		serial_data_o = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask : hold
	// Fewer than 16 rises cuts the frame short
	task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d,
		input logic pad, input int n, output logic [7:0] q);
		logic [15:0] bits;
		bits = {d, pad, 1'b0, a, rd};
		q = 8'h00;
		@(posedge clk_i);
		select_n_o <= 1'b0;
		serial_data_o <= bits[0];
		hold(8);
		for (int i = 0; i < n; i++) begin
			serial_clk_o <= 1'b1;
			hold(4);
			serial_clk_o <= 1'b0;
			@(negedge clk_i);
			// An undriven pin reads as unknown so a stale level never passes
			if (i >= 8) q[i-8] = serial_data_out_oe_i ? serial_data_out_i : 1'bx;
			hold(1);
			if (i < 15) serial_data_o <= bits[i+1];
			hold(3);
		end
		select_n_o <= 1'b1;
		serial_data_o <= ~serial_data_o;
		hold(4);
	endtask : xfer
endmodule : hsp_host_model

/* File: tb/tb_top.sv */
// Self-checking bench for the host serial register port
`timescale 1ns/10ps
module tb_top;
	import hsp_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic mode = 1'b0;
	logic [4:0] rd_addr = 5'h00;
	logic sel_n, sclk, serial_data_in, serial_data_out, sdo_oe, strobe;
	logic [7:0] rd_data, payload, q;
	logic [4:0] index;
	logic [7:0] exp_bank [32];
	int n_mismatch = 0;
	int comparisons = 0;
	int n_strobe = 0;
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) if (strobe === 1'b1) n_strobe++;
	hsp_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
		.control_mode_select_i(mode), .select_n_i(sel_n), .serial_clk_i(sclk),
		.serial_data_in_i(serial_data_in), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(sdo_oe),
		.reg_rd_addr_i(rd_addr), .reg_rd_data_o(rd_data), .register_index_o(index),
		.payload_byte_o(payload), .reg_wr_strobe_o(strobe));
	hsp_host_model host (.clk_i(clk_i), .select_n_o(sel_n), .serial_clk_o(sclk),
		.serial_data_o(serial_data_in), .serial_data_out_i(serial_data_out), .serial_data_out_oe_i(sdo_oe));
	task automatic check(input string nm, input logic [7:0] got, input logic [7:0] want);
		comparisons++;
		if (got !== want) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, want, got);
		end
	endtask : check
	task automatic final_report();
		if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : final_report
	// Write a frame; only a whole frame in host mode may land in the bank
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input int n);
		int s0;
		s0 = n_strobe;
		host.xfer(1'b0, a, d, 1'($urandom), n, q);
		rd_addr <= a;
		@(negedge clk_i);
		check("strobes", 8'(n_strobe - s0), (n == 16 && !mode) ? 8'h01 : 8'h00);
		if (n == 16 && !mode) begin
			exp_bank[a] = d;
			check("index", {3'h0, index}, {3'h0, a});
			check("payload", payload, d);
		end
		check("bank", rd_data, exp_bank[a]);
	endtask : wr
	initial begin
		#400000;
		n_mismatch++;
		final_report();
	end
	initial begin
		for (int i = 0; i < 32; i++) exp_bank[i] = HSP_REG_RESET;
		void'($urandom(32'h2008a180));
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		for (int i = 0; i < 40; i++)
			wr(i == 0 ? 5'h00 : i == 1 ? 5'h1f : 5'($urandom), i == 0 ? 8'hff : 8'($urandom), 16);
		wr(5'h1f, 8'h5a, 12);
		wr(5'h00, 8'h3c, 15);
		@(posedge clk_i);
		mode <= 1'b1;
		repeat (4) @(posedge clk_i);
		wr(5'h00, 8'hc3, 16);
		@(posedge clk_i);
		mode <= 1'b0;
		repeat (4) @(posedge clk_i);
		for (int i = 0; i < 32; i++) begin
			host.xfer(1'b1, 5'(i), 8'($urandom), 1'($urandom), 16, q);
			rd_addr <= 5'(i);
			@(negedge clk_i);
			check("serial read", q, exp_bank[i]);
			check("bank read", rd_data, exp_bank[i]);
		end
		final_report();
	end
endmodule : tb_top
